// ### common/cdrs_div_if.sv
`default_nettype none
interface cdrs_div_if #(parameter int W = 8);
    logic [W-1:0] divisor;
    logic         tick;
    modport ctrl (output divisor, input tick);
    modport div  (input divisor, output tick);
endinterface
`default_nettype wire

// ### common/cdrs_pkg.sv
`default_nettype none
package cdrs_pkg;
    // -------------------------------------------------------------
    // bus
    // -------------------------------------------------------------
    localparam int               ADDR_W        = 8;
    localparam int               DATA_W        = 32;
    localparam logic [ADDR_W-1:0] CPU_DIV_OFF   = 8'h04;
    localparam logic [ADDR_W-1:0] SLOW_DIV_OFF  = 8'h08;
    localparam logic [ADDR_W-1:0] OSC_STAT_OFF  = 8'h0c;
    localparam logic [ADDR_W-1:0] PWR_STAT_OFF  = 8'h10;
    localparam logic [ADDR_W-1:0] IRQ_STAT_OFF  = 8'h20;
    localparam logic [ADDR_W-1:0] IRQ_CLR_OFF   = 8'h24;
    localparam logic [ADDR_W-1:0] IRQ_EN_OFF    = 8'h28;

    // -------------------------------------------------------------
    // fields and reset values
    // -------------------------------------------------------------
    localparam int               CPU_DIV_W      = 8;
    localparam int               SLOW_DIV_W     = 10;
    localparam logic [7:0]       CPU_DIV_RESET  = 8'h04;
    localparam logic [9:0]       SLOW_DIV_RESET = 10'h1e0;
    localparam int               PLL_LOCK_BIT   = 8;
    localparam int               EXT_PRES_BIT   = 10;
    localparam int               DBG_PIN_BIT    = 7;
    localparam int               SYS_FLAG_BIT   = 6;
    localparam int               BAT_FLAG_BIT   = 5;
    localparam logic             PLL_RESET      = 1'b0;
    localparam logic             DBG_PIN_RESET  = 1'b1;
    localparam logic             SYS_FLAG_RESET = 1'b1;
    localparam logic             BAT_FLAG_RESET = 1'b0;

    // -------------------------------------------------------------
    // interrupt bits
    // -------------------------------------------------------------
    localparam int               IRQ_W          = 4;
    localparam int               IRQ_SYS        = 0;
    localparam int               IRQ_BAT        = 1;
    localparam int               IRQ_EXT        = 2;
    localparam int               IRQ_PLL        = 3;
    localparam logic [IRQ_W-1:0] IRQ_STAT_RESET = 4'h1;
    localparam logic [IRQ_W-1:0] IRQ_EN_RESET   = 4'h0;

    // -------------------------------------------------------------
    // timing
    // -------------------------------------------------------------
    localparam int               CLK_PERIOD_NS  = 50;
    localparam int               EXT_WINDOW_NS  = 100000;
    localparam int               EXT_CNT_W      = 12;
    localparam logic [EXT_CNT_W-1:0] EXT_WINDOW_CYC =
        EXT_CNT_W'(EXT_WINDOW_NS / CLK_PERIOD_NS);
endpackage
`default_nettype wire

// ### logic/cdrs_clock_divider_reset_status.sv
// Design decision made here: the APB interface to the registers.
`default_nettype none
module cdrs_clock_divider_reset_status
    import cdrs_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [DATA_W-1:0] pwdata,
    output var  logic [DATA_W-1:0] prdata,
    output var  logic              pready,
    output var  logic              pslverr,
    input  wire logic              pllLockedIn,
    input  wire logic              ext32kIn,
    input  wire logic              ringOscIn,
    input  wire logic              debugResetPinIn,
    input  wire logic              batteryResetPulse,
    output var  logic              cpuClkTick,
    output var  logic              slowClkTick,
    output var  logic              lowClk,
    output var  logic              lowClkFromPin,
    output var  logic              irq
);

    // -------------------------------------------------------------
    // decode helper
    // -------------------------------------------------------------
    function automatic logic regHit(
        input logic [ADDR_W-1:0] addr,
        input logic [ADDR_W-1:0] off
    );
        regHit = (addr == off);
    endfunction

    // -------------------------------------------------------------
    // declarations
    // -------------------------------------------------------------
    logic [DATA_W-1:0]    prdataReg;
    logic [DATA_W-1:0]    prdataNext;
    logic                 preadyReg;
    logic                 preadyNext;
    logic                 pslverrReg;
    logic                 pslverrNext;
    logic                 wrEn;

    logic [CPU_DIV_W-1:0]  cpuDivReg;
    logic [CPU_DIV_W-1:0]  cpuDivNext;
    logic [SLOW_DIV_W-1:0] slowDivReg;
    logic [SLOW_DIV_W-1:0] slowDivNext;
    logic [IRQ_W-1:0]      irqEnReg;
    logic [IRQ_W-1:0]      irqEnNext;

    logic                 pllLockReg;
    logic                 pllLockNext;
    logic                 dbgPinReg;
    logic                 dbgPinNext;
    logic                 sysFlagReg;
    logic                 sysFlagNext;
    logic                 batFlagReg;
    logic                 batFlagNext;
    logic                 pwrClr;

    logic                 extInReg;
    logic                 extPrevReg;
    logic                 extEdge;
    logic [EXT_CNT_W-1:0] extCntReg;
    logic [EXT_CNT_W-1:0] extCntNext;
    logic                 extPresReg;
    logic                 extPresNext;
    logic                 lowClkReg;
    logic                 lowClkNext;

    logic [IRQ_W-1:0]     irqEvt;
    logic [IRQ_W-1:0]     irqClr;
    logic [IRQ_W-1:0]     irqStatReg;
    logic [IRQ_W-1:0]     irqStatNext;
    logic                 irqReg;
    logic                 irqNext;

    cdrs_div_if #(.W(CPU_DIV_W))  cpuDivIf ();
    cdrs_div_if #(.W(SLOW_DIV_W)) slowDivIf ();

    // -------------------------------------------------------------
    // apb slave: answer in the cycle after setup
    // -------------------------------------------------------------
    assign wrEn = psel & penable & preadyReg & pwrite;

    always_comb begin
        prdataNext  = '0;
        preadyNext  = 1'b0;
        pslverrNext = 1'b0;
        if (psel && !penable) begin
            preadyNext = 1'b1;
            case (paddr)
                CPU_DIV_OFF:
                    prdataNext[CPU_DIV_W-1:0] = cpuDivReg;
                SLOW_DIV_OFF:
                    prdataNext[SLOW_DIV_W-1:0] = slowDivReg;
                OSC_STAT_OFF:
                    prdataNext[PLL_LOCK_BIT] = pllLockReg;
                PWR_STAT_OFF: begin
                    prdataNext[EXT_PRES_BIT] = extPresReg;
                    prdataNext[DBG_PIN_BIT]  = dbgPinReg;
                    prdataNext[SYS_FLAG_BIT] = sysFlagReg;
                    prdataNext[BAT_FLAG_BIT] = batFlagReg;
                end
                IRQ_STAT_OFF:
                    prdataNext[IRQ_W-1:0] = irqStatReg;
                IRQ_CLR_OFF:
                    prdataNext = '0;
                IRQ_EN_OFF:
                    prdataNext[IRQ_W-1:0] = irqEnReg;
                default:
                    pslverrNext = 1'b1;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            prdataReg  <= '0;
            preadyReg  <= 1'b0;
            pslverrReg <= 1'b0;
        end else begin
            prdataReg  <= prdataNext;
            preadyReg  <= preadyNext;
            pslverrReg <= pslverrNext;
        end
    end

    assign prdata  = prdataReg;
    assign pready  = preadyReg;
    assign pslverr = pslverrReg;

    // -------------------------------------------------------------
    // configuration registers
    // -------------------------------------------------------------
    always_comb begin
        cpuDivNext  = cpuDivReg;
        slowDivNext = slowDivReg;
        irqEnNext   = irqEnReg;
        if (wrEn && regHit(paddr, CPU_DIV_OFF)) begin
            cpuDivNext = pwdata[CPU_DIV_W-1:0];
        end
        if (wrEn && regHit(paddr, SLOW_DIV_OFF)) begin
            slowDivNext = pwdata[SLOW_DIV_W-1:0];
        end
        if (wrEn && regHit(paddr, IRQ_EN_OFF)) begin
            irqEnNext = pwdata[IRQ_W-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cpuDivReg  <= CPU_DIV_RESET;
            slowDivReg <= SLOW_DIV_RESET;
            irqEnReg   <= IRQ_EN_RESET;
        end else begin
            cpuDivReg  <= cpuDivNext;
            slowDivReg <= slowDivNext;
            irqEnReg   <= irqEnNext;
        end
    end

    // -------------------------------------------------------------
    // clock dividers
    // -------------------------------------------------------------
    assign cpuDivIf.divisor  = cpuDivReg;
    assign slowDivIf.divisor = slowDivReg;

    cdrs_divider #(.W(CPU_DIV_W)) cpuDivider (
        .clk  (clk),
        .rst  (rst),
        .port (cpuDivIf)
    );

    cdrs_divider #(.W(SLOW_DIV_W)) slowDivider (
        .clk  (clk),
        .rst  (rst),
        .port (slowDivIf)
    );

    assign cpuClkTick  = cpuDivIf.tick;
    assign slowClkTick = slowDivIf.tick;

    // -------------------------------------------------------------
    // external 32k activity and clock source
    // -------------------------------------------------------------
    assign extEdge = extInReg ^ extPrevReg;

    always_comb begin
        if (extEdge) begin
            extCntNext = EXT_WINDOW_CYC;
        end else if (extCntReg != '0) begin
            extCntNext = extCntReg - EXT_CNT_W'(1);
        end else begin
            extCntNext = '0;
        end
        extPresNext = (extCntNext != '0);
        lowClkNext  = extPresReg ? extInReg : ringOscIn;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            extInReg   <= 1'b0;
            extPrevReg <= 1'b0;
            extCntReg  <= '0;
            extPresReg <= 1'b0;
            lowClkReg  <= 1'b0;
        end else begin
            extInReg   <= ext32kIn;
            extPrevReg <= extInReg;
            extCntReg  <= extCntNext;
            extPresReg <= extPresNext;
            lowClkReg  <= lowClkNext;
        end
    end

    assign lowClk        = lowClkReg;
    assign lowClkFromPin = extPresReg;

    // -------------------------------------------------------------
    // status bits and reset flags
    // -------------------------------------------------------------
    assign pwrClr = wrEn & regHit(paddr, PWR_STAT_OFF);

    always_comb begin
        pllLockNext = pllLockedIn;
        dbgPinNext  = debugResetPinIn;
        sysFlagNext = sysFlagReg & ~(pwrClr & pwdata[SYS_FLAG_BIT]);
        batFlagNext = batteryResetPulse |
                      (batFlagReg & ~(pwrClr & pwdata[BAT_FLAG_BIT]));
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pllLockReg <= PLL_RESET;
            dbgPinReg  <= DBG_PIN_RESET;
            sysFlagReg <= SYS_FLAG_RESET;
            batFlagReg <= BAT_FLAG_RESET;
        end else begin
            pllLockReg <= pllLockNext;
            dbgPinReg  <= dbgPinNext;
            sysFlagReg <= sysFlagNext;
            batFlagReg <= batFlagNext;
        end
    end

    // -------------------------------------------------------------
    // interrupts: sticky status, write-one clear, enable
    // -------------------------------------------------------------
    always_comb begin
        irqEvt          = '0;
        irqEvt[IRQ_BAT] = batteryResetPulse;
        irqEvt[IRQ_EXT] = extPresNext ^ extPresReg;
        irqEvt[IRQ_PLL] = pllLockNext ^ pllLockReg;
        irqClr = '0;
        if (wrEn && regHit(paddr, IRQ_CLR_OFF)) begin
            irqClr = pwdata[IRQ_W-1:0];
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < IRQ_W; gi++) begin : gIrq
            assign irqStatNext[gi] =
                irqEvt[gi] | (irqStatReg[gi] & ~irqClr[gi]);
        end
    endgenerate

    always_comb begin
        irqNext = |(irqStatNext & irqEnNext);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            irqStatReg <= IRQ_STAT_RESET;
            irqReg     <= 1'b0;
        end else begin
            irqStatReg <= irqStatNext;
            irqReg     <= irqNext;
        end
    end

    assign irq = irqReg;

endmodule
`default_nettype wire

// ### logic/cdrs_divider.sv
`default_nettype none
module cdrs_divider #(
    parameter int W = 8
) (
    input  wire logic clk,
    input  wire logic rst,
    cdrs_div_if.div   port
);
    logic [W-1:0] cntReg;
    logic [W-1:0] cntNext;
    logic         tickReg;
    logic         tickNext;

    // -------------------------------------------------------------
    // counter, one tick every divisor cycles, none at zero
    // -------------------------------------------------------------
    always_comb begin
        cntNext  = '0;
        tickNext = 1'b0;
        if (port.divisor != '0) begin
            if (cntReg >= port.divisor - W'(1)) begin
                cntNext  = '0;
                tickNext = 1'b1;
            end else begin
                cntNext  = cntReg + W'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cntReg  <= '0;
            tickReg <= 1'b0;
        end else begin
            cntReg  <= cntNext;
            tickReg <= tickNext;
        end
    end

    assign port.tick = tickReg;
endmodule
`default_nettype wire

// ### sim/cdrs_monitor.sv
`default_nettype none
module cdrs_monitor
    import cdrs_pkg::*;
(
    input wire logic              clk,
    input wire logic              rst,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              ext32kIn,
    input wire logic              cpuClkTick,
    input wire logic              slowClkTick,
    input wire logic              lowClkFromPin
);
    // ---------------------------------------------
    // pin quiet time
    // ---------------------------------------------
    logic [11:0] quiet_reg;
    logic [11:0] quiet_next;
    logic        extPrev_reg;
    logic        rdSetup;

    assign rdSetup = psel && !penable && !pwrite;

    always_comb begin
        quiet_next = quiet_reg + {11'h0, quiet_reg != 12'hfff};
        if (ext32kIn != extPrev_reg) begin
            quiet_next = 12'h0;
        end
    end

    always_ff @(posedge clk) begin
        quiet_reg <= rst ? 12'h0 : quiet_next;
        extPrev_reg <= ext32kIn;
    end

    // ---------------------------------------------
    // properties
    // ---------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence setupS;
        psel && !penable;
    endsequence
    sequence accessS;
        psel && penable && pready ##1 !pready;
    endsequence

    ready_after_setup_a: assert property (setupS |=> accessS)
        else $error("ready not one cycle after setup");
    bad_addr_err_a: assert property (
        psel && !penable && paddr == 8'h00 |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    osc_reserved_a: assert property (
        rdSetup && paddr == OSC_STAT_OFF |=>
        prdata[31:9] == 23'h0 && prdata[7:0] == 8'h00)
        else $error("oscillator reserved bits set");
    pwr_reserved_a: assert property (
        rdSetup && paddr == PWR_STAT_OFF |=> prdata[31:11] == 21'h0
        && prdata[9:8] == 2'h0 && prdata[4:0] == 5'h00)
        else $error("status reserved bits set");
    div_reserved_a: assert property (
        rdSetup && paddr == CPU_DIV_OFF |=> prdata[31:8] == 24'h0)
        else $error("cpu divider reserved bits set");
    slow_reserved_a: assert property (
        rdSetup && paddr == SLOW_DIV_OFF |=> prdata[31:10] == 22'h0)
        else $error("slow divider reserved bits set");
    presence_rise_a: assert property (
        $changed(ext32kIn) |-> ##[1:4] lowClkFromPin)
        else $error("pin edge not seen as presence");
    presence_drop_a: assert property (
        quiet_reg > 12'h7da |-> !lowClkFromPin)
        else $error("presence kept on silent pin");
    cpu_tick_start_a: assert property (
        $fell(rst) |-> ##[1:6] cpuClkTick)
        else $error("no cpu tick after reset");
    slow_tick_wait_a: assert property (
        $fell(rst) |-> !slowClkTick [*8])
        else $error("slow tick too early after reset");
endmodule

bind cdrs_clock_divider_reset_status cdrs_monitor mon (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext32kIn(ext32kIn), .cpuClkTick(cpuClkTick),
    .slowClkTick(slowClkTick), .lowClkFromPin(lowClkFromPin)
);
`default_nettype wire

// ### sim/tb_top.sv
`default_nettype none
module tb_top import cdrs_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, pll = 1'b0, ext = 1'b0, ring = 1'b0;
    logic dbg = 1'b1, bat = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, cpuTick, slowTick, lowClk, fromPin, irq;
    int errors = 0, numChecks = 0, g, n;
    int dv[5] = '{1, 3, 4, 16, 48};

    always #25 clk = ~clk;

    cdrs_clock_divider_reset_status dut (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pllLockedIn(pll), .ext32kIn(ext), .ringOscIn(ring),
        .debugResetPinIn(dbg), .batteryResetPulse(bat),
        .cpuClkTick(cpuTick), .slowClkTick(slowTick), .lowClk(lowClk),
        .lowClkFromPin(fromPin), .irq(irq)
    );

    // ---------------------------------------------
    // access tasks
    // ---------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        numChecks++;
        if (got !== exp) begin
            $display("unexpected %0t got %h exp %h", $time, got, exp);
            errors++;
        end
    endtask

    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, input logic e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        if (!w) begin
            chk(prdata, d);
        end
        chk({31'h0, pslverr}, {31'h0, e});
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] x,
                      input logic e = 1'b0);
        xfer(1'b0, a, x, e);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic e = 1'b0);
        xfer(1'b1, a, d, e);
    endtask

    // cycles between two ticks of the chosen divider
    task automatic gap(input bit s, output int c);
        int k;
        k = 0;
        c = 0;
        do @(posedge clk); while ((s ? slowTick : cpuTick) !== 1'b1
                                   && k++ < 600);
        do begin
            @(posedge clk);
            c++;
        end while ((s ? slowTick : cpuTick) !== 1'b1 && c < 600);
    endtask

    task automatic complete_run;
        if (errors == 0 && numChecks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ---------------------------------------------
    // tests
    // ---------------------------------------------
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(CPU_DIV_OFF, 32'h4);
        rd(SLOW_DIV_OFF, 32'h1e0);
        rd(OSC_STAT_OFF, 32'h0);
        rd(PWR_STAT_OFF, 32'hc0);
        rd(IRQ_STAT_OFF, 32'h1);
        rd(8'h00, 32'h0, 1'b1);
        wr(8'h02, 32'hffffffff, 1'b1);
        wr(OSC_STAT_OFF, 32'hffffffff);
        rd(OSC_STAT_OFF, 32'h0);
        foreach (dv[i]) begin
            wr(CPU_DIV_OFF, 32'hffffff00 | dv[i]);
            rd(CPU_DIV_OFF, dv[i]);
            gap(1'b0, g);
            gap(1'b0, g);
            chk(g, dv[i]);
        end
        wr(SLOW_DIV_OFF, 32'h5);
        gap(1'b1, g);
        gap(1'b1, g);
        chk(g, 32'h5);
        wr(SLOW_DIV_OFF, 32'hfffffc00);
        rd(SLOW_DIV_OFF, 32'h0);
        n = 0;
        repeat (600) begin
            @(posedge clk);
            if (slowTick !== 1'b0) n++;
        end
        chk(n, 32'h0);
        wr(IRQ_EN_OFF, 32'h2);
        bat <= 1'b1;
        @(posedge clk);
        bat <= 1'b0;
        repeat (3) @(posedge clk);
        chk(irq, 32'h1);
        rd(PWR_STAT_OFF, 32'he0);
        wr(IRQ_CLR_OFF, 32'h2);
        repeat (2) @(posedge clk);
        chk(irq, 32'h0);
        rd(IRQ_STAT_OFF, 32'h1);
        fork
            wr(PWR_STAT_OFF, 32'h20);
            begin
                @(posedge clk);
                bat <= 1'b1;
                @(posedge clk);
                bat <= 1'b0;
            end
        join
        rd(PWR_STAT_OFF, 32'he0);
        wr(PWR_STAT_OFF, 32'h60);
        rd(PWR_STAT_OFF, 32'h80);
        wr(IRQ_EN_OFF, 32'h0);
        repeat (2) @(posedge clk);
        chk(irq, 32'h0);
        wr(IRQ_EN_OFF, 32'h2);
        repeat (2) @(posedge clk);
        chk(irq, 32'h1);
        wr(IRQ_CLR_OFF, 32'hf);
        rd(IRQ_STAT_OFF, 32'h0);
        pll <= 1'b1;
        dbg <= 1'b0;
        repeat (3) @(posedge clk);
        rd(OSC_STAT_OFF, 32'h100);
        rd(PWR_STAT_OFF, 32'h0);
        repeat (7) begin
            ext <= ~ext;
            repeat (5) @(posedge clk);
        end
        rd(PWR_STAT_OFF, 32'h400);
        rd(IRQ_STAT_OFF, 32'hc);
        chk(lowClk, 32'h1);
        repeat (2100) @(posedge clk);
        chk(fromPin, 32'h0);
        chk(lowClk, 32'h0);
        ring <= 1'b1;
        repeat (4) @(posedge clk);
        chk(lowClk, 32'h1);
        rd(PWR_STAT_OFF, 32'h0);
        fork
            wr(PWR_STAT_OFF, 32'h40);
            begin
                @(posedge clk);
                dbg <= 1'b1;
                ext <= 1'b0;
                rst <= 1'b1;
            end
        join
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(PWR_STAT_OFF, 32'hc0);
        rd(CPU_DIV_OFF, 32'h4);
        rd(IRQ_EN_OFF, 32'h0);
        rd(IRQ_STAT_OFF, 32'h9);
        complete_run;
    end

    initial begin
        #(10000 * 50);
        errors++;
        complete_run;
    end
endmodule
`default_nettype wire
